// ---- shared/rirq_pkg.sv ----
package rirq_pkg;

  // Register offsets on the serial link (7-bit address field).
  localparam logic [6:0] A_CHIP  = 7'h00;
  localparam logic [6:0] A_PROT  = 7'h01;
  localparam logic [6:0] A_NRW   = 7'h07;
  localparam logic [6:0] A_IRQ   = 7'h0C;
  localparam logic [6:0] A_COLP  = 7'h0E;
  localparam logic [6:0] A_COLC  = 7'h10;
  localparam logic [6:0] A_FSTAT = 7'h1C;
  localparam logic [6:0] A_FIFO  = 7'h1F;

  // Cause bit positions in the interrupt cause register; B_CRC_OFF is the CRC disable bit of the protocol register.
  localparam int B_TX  = 7;
  localparam int B_RX  = 6;
  localparam int B_LVL = 5;
  localparam int B_CRC = 4;
  localparam int B_PAR = 3;
  localparam int B_FRM = 2;
  localparam int B_COL = 1;
  localparam int B_NR  = 0;
  localparam int B_CRC_OFF = 7;

  // FIFO size and level thresholds.
  localparam logic [3:0] FIFO_DEPTH = 4'hC;
  localparam logic [3:0] FIFO_LAST  = 4'hB;
  localparam logic [3:0] LVL_TX     = 4'h4;
  localparam logic [3:0] LVL_RX     = 4'h8;

  // Link frame length is sixteen bits; this is the last bit index.
  localparam logic [3:0] FRAME_LAST = 4'hF;

  // Clock output timing.
  localparam int CLK_HZ       = 100000000;
  localparam int CLK_NS       = 10;
  localparam int AUX_HZ       = 60000;
  localparam int AUX_HALF_CYC = CLK_HZ / (2 * AUX_HZ);
  localparam logic [9:0] AUX_HALF  = 10'(AUX_HALF_CYC - 1);
  localparam logic [9:0] FAST_HALF = 10'h003;

  // No-response wait register counts in steps of this length.
  localparam int NR_UNIT_NS  = 1000;
  localparam int NR_UNIT_CYC = NR_UNIT_NS / CLK_NS;
  localparam logic [6:0] NR_UNIT = 7'(NR_UNIT_CYC - 1);

  // Values after reset.
  localparam logic [7:0] RST_CHIP = 8'h00;
  localparam logic [7:0] RST_PROT = 8'h00;
  localparam logic [7:0] RST_NRW  = 8'h10;
  localparam logic [7:0] RST_COLC = 8'h03;

  typedef enum logic [1:0] {
    CK_AUX  = 2'b00,
    CK_WAIT = 2'b01,
    CK_FAST = 2'b10
  } rirq_ck_t;

  typedef struct packed {
    logic tx_start;
    logic tx_done;
    logic rx_start;
    logic rx_done;
    logic crc_err;
    logic par_err;
    logic frm_err;
    logic col_a;
    logic col_v;
  } rirq_ev_t;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } rirq_frame_t;

endpackage

// ---- hdl/rirq_core.sv ----
// Function
// - Interrupt pin prompts controller to read causes.
// - Bit 7 at transmit start, pin at end.
// - Bit 6 at receive start, pin at end.
// - Bit 5 on FIFO low/high level.
// - Bit 4 CRC error unless disabled.
// - Bit 3 parity, bit 2 framing errors.
// - Bit 1 collision, enabled per configuration.
// - Bit 0 when no response in time.
// - Twelve byte FIFO for frame data.
// - Auxiliary 60 kHz clock out from power-up.
// - Enable starts oscillator, then switches clock.
// - Controller link is a serial interface.
// - Collision position: byte high, bit low.
module rirq_core (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Serial link from the controller
  input  wire logic              data_clk,
  input  wire logic              ss_n,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe,
  // Reader front-end events and data
  input  rirq_pkg::rirq_ev_t     ev,
  input  wire logic [7:0]        col_pos,
  input  wire logic              rx_push,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              tx_pop,
  output logic [7:0]             tx_data,
  output logic                   irq,
  // Power and clock output
  input  wire logic              en,
  input  wire logic              osc_ok,
  output logic                   supply_osc_en,
  output logic                   reader_clock_out
);

  logic                   lrst_n;
  logic [3:0]             bcnt_q, bcnt_d;
  logic [14:0]            sh_q, sh_d;
  logic [7:0]             mo_q, mo_d;
  logic                   oe_q, oe_d;
  logic [15:0]            lw_q, lw_d;
  logic                   lt_q, lt_d;
  logic [7:0]             rd_q, rd_d;
  logic [2:0]             rq_q;
  logic [1:0]             en_q, os_q;
  rirq_pkg::rirq_frame_t  fr;
  logic                   take, wr, rdx;
  logic [7:0]             chip_q, chip_d, prot_q, prot_d, nrw_q, nrw_d;
  logic [7:0]             colc_q, colc_d, colp_q, colp_d;
  logic [7:0]             cause_q, cause_d, set_v;
  logic                   irq_q, irq_d, raise, clr;
  logic [7:0]             mem_q [12];
  logic [3:0]             wp_q, wp_d, rp_q, rp_d, cnt_q, cnt_d;
  logic                   push, pop, flush;
  logic [7:0]             pdata, txd_q, txd_d;
  logic                   txa_q, txa_d, rxa_q, rxa_d, lvl, lvl_q;
  logic                   nr_on_q, nr_on_d, nr_fire;
  logic [7:0]             nr_left_q, nr_left_d;
  logic [6:0]             nr_sub_q, nr_sub_d;
  rirq_pkg::rirq_ck_t     ck_q, ck_d;
  logic [9:0]             div_q, div_d, half;
  logic                   co_q, co_d, se_q;

  // The select line clears the bit position, so a torn frame never leaks into the next.
  assign lrst_n = rstn & ~ss_n;

  always_comb
  begin
    bcnt_d = bcnt_q + 4'h1;
    sh_d   = {sh_q[13:0], mosi};
    oe_d   = 1'b1;
    mo_d   = (bcnt_q == 4'h0) ? rd_q : {mo_q[6:0], 1'b0};
    lw_d   = lw_q;
    lt_d   = lt_q;
    if (bcnt_q == rirq_pkg::FRAME_LAST)
    begin
      lw_d = {sh_q, mosi};
      lt_d = ~lt_q;
    end
  end

  always_ff @(posedge data_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      bcnt_q <= 4'h0;
      sh_q   <= 15'h0000;
      mo_q   <= 8'h00;
      oe_q   <= 1'b0;
    end
    else
    begin
      bcnt_q <= bcnt_d;
      sh_q   <= sh_d;
      mo_q   <= mo_d;
      oe_q   <= oe_d;
    end
  end

  always_ff @(posedge data_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lw_q <= 16'h0000;
      lt_q <= 1'b0;
    end
    else
    begin
      lw_q <= lw_d;
      lt_q <= lt_d;
    end
  end

  assign miso    = mo_q[7];
  assign miso_oe = oe_q;

  // The frame word is only read after its toggle has crossed, when it is long stable.
  assign fr    = rirq_pkg::rirq_frame_t'(lw_q);
  assign take  = rq_q[2] ^ rq_q[1];
  assign wr    = take & ~fr.rd;
  assign rdx   = take & fr.rd;
  assign clr   = rdx & (fr.addr == rirq_pkg::A_IRQ);
  assign flush = wr & (fr.addr == rirq_pkg::A_FSTAT);

  assign push  = ((wr & (fr.addr == rirq_pkg::A_FIFO)) | rx_push) & (cnt_q != rirq_pkg::FIFO_DEPTH);
  // Only a link write to the data port may steer the push; other writes leave the receive byte in charge.
  assign pdata = (wr & (fr.addr == rirq_pkg::A_FIFO)) ? fr.data : rx_byte;
  assign pop   = ((rdx & (fr.addr == rirq_pkg::A_FIFO)) | tx_pop) & (cnt_q != 4'h0);

  assign lvl = (txa_q & (cnt_q < rirq_pkg::LVL_TX)) | (rxa_q & (cnt_q > rirq_pkg::LVL_RX));
  assign nr_fire = nr_on_q & ~ev.tx_done & ~ev.rx_start & (nr_sub_q == 7'h00) & (nr_left_q == 8'h00);

  always_comb
  begin
    set_v = 8'h00;
    set_v[rirq_pkg::B_TX]  = ev.tx_start | ev.tx_done;
    set_v[rirq_pkg::B_RX]  = ev.rx_start | ev.rx_done;
    set_v[rirq_pkg::B_LVL] = lvl & ~lvl_q;
    set_v[rirq_pkg::B_CRC] = ev.crc_err & ~prot_q[rirq_pkg::B_CRC_OFF];
    set_v[rirq_pkg::B_PAR] = ev.par_err;
    set_v[rirq_pkg::B_FRM] = ev.frm_err;
    set_v[rirq_pkg::B_COL] = (ev.col_a & colc_q[0]) | (ev.col_v & colc_q[1]);
    set_v[rirq_pkg::B_NR]  = nr_fire;
    // Start flags alone only latch; the pin waits for the matching end.
    raise   = ev.tx_done | ev.rx_done | (|set_v[5:0]);
    // A new event in the clearing cycle is kept, so set wins over clear.
    cause_d = (clr ? 8'h00 : cause_q) | set_v;
    irq_d   = (clr ? 1'b0 : irq_q) | raise;
  end

  always_comb
  begin
    chip_d = chip_q;
    prot_d = prot_q;
    nrw_d  = nrw_q;
    colc_d = colc_q;
    colp_d = colp_q;
    rd_d   = rd_q;
    if (wr)
    begin
      unique case (fr.addr)
        rirq_pkg::A_CHIP: chip_d = fr.data;
        rirq_pkg::A_PROT: prot_d = fr.data;
        rirq_pkg::A_NRW:  nrw_d  = fr.data;
        rirq_pkg::A_COLC: colc_d = fr.data;
        default:          chip_d = chip_q;
      endcase
    end
    if (ev.col_a | ev.col_v)
      colp_d = col_pos;
    if (rdx)
    begin
      unique case (fr.addr)
        rirq_pkg::A_CHIP:  rd_d = chip_q;
        rirq_pkg::A_PROT:  rd_d = prot_q;
        rirq_pkg::A_NRW:   rd_d = nrw_q;
        rirq_pkg::A_IRQ:   rd_d = cause_q;
        rirq_pkg::A_COLP:  rd_d = colp_q;
        rirq_pkg::A_COLC:  rd_d = colc_q;
        rirq_pkg::A_FSTAT: rd_d = {4'h0, cnt_q};
        rirq_pkg::A_FIFO:  rd_d = mem_q[rp_q];
        default:           rd_d = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    txd_d = txd_q;
    if (push)
      wp_d = (wp_q == rirq_pkg::FIFO_LAST) ? 4'h0 : wp_q + 4'h1;
    if (pop)
      rp_d = (rp_q == rirq_pkg::FIFO_LAST) ? 4'h0 : rp_q + 4'h1;
    if (tx_pop & pop)
      txd_d = mem_q[rp_q];
    if (push & ~pop)
      cnt_d = cnt_q + 4'h1;
    else if (pop & ~push)
      cnt_d = cnt_q - 4'h1;
    if (flush)
    begin
      wp_d  = 4'h0;
      rp_d  = 4'h0;
      cnt_d = 4'h0;
    end
    txa_d = ev.tx_start | (txa_q & ~ev.tx_done);
    rxa_d = ev.rx_start | (rxa_q & ~ev.rx_done);
  end

  always_comb
  begin
    nr_on_d   = nr_on_q;
    nr_left_d = nr_left_q;
    nr_sub_d  = nr_sub_q;
    if (ev.tx_done)
    begin
      nr_on_d   = 1'b1;
      nr_left_d = nrw_q;
      nr_sub_d  = rirq_pkg::NR_UNIT;
    end
    else if (nr_on_q)
    begin
      if (ev.rx_start | nr_fire)
        nr_on_d = 1'b0;
      else if (nr_sub_q != 7'h00)
        nr_sub_d = nr_sub_q - 7'h01;
      else
      begin
        nr_left_d = nr_left_q - 8'h01;
        nr_sub_d  = rirq_pkg::NR_UNIT;
      end
    end
  end

  // Mode changes happen only at a half-period boundary, so no runt pulse reaches the controller.
  always_comb
  begin
    half  = (ck_q == rirq_pkg::CK_FAST) ? rirq_pkg::FAST_HALF : rirq_pkg::AUX_HALF;
    div_d = div_q + 10'h001;
    co_d  = co_q;
    ck_d  = ck_q;
    if (div_q >= half)
    begin
      div_d = 10'h000;
      co_d  = ~co_q;
      unique case (ck_q)
        rirq_pkg::CK_AUX:  if (en_q[1]) ck_d = rirq_pkg::CK_WAIT;
        rirq_pkg::CK_WAIT: if (!en_q[1]) ck_d = rirq_pkg::CK_AUX;
                           else if (os_q[1] && co_q) ck_d = rirq_pkg::CK_FAST;
        rirq_pkg::CK_FAST: if (!en_q[1] && co_q) ck_d = rirq_pkg::CK_AUX;
        default:           ck_d = rirq_pkg::CK_AUX;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wp_q] <= pdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rq_q <= 3'h0; en_q <= 2'h0; os_q <= 2'h0;
      chip_q <= rirq_pkg::RST_CHIP; prot_q <= rirq_pkg::RST_PROT;
      nrw_q <= rirq_pkg::RST_NRW; colc_q <= rirq_pkg::RST_COLC;
      colp_q <= 8'h00; rd_q <= 8'h00; cause_q <= 8'h00; irq_q <= 1'b0;
      wp_q <= 4'h0; rp_q <= 4'h0; cnt_q <= 4'h0; txd_q <= 8'h00;
      txa_q <= 1'b0; rxa_q <= 1'b0; lvl_q <= 1'b0;
      nr_on_q <= 1'b0; nr_left_q <= 8'h00; nr_sub_q <= 7'h00;
      ck_q <= rirq_pkg::CK_AUX; div_q <= 10'h000; co_q <= 1'b0; se_q <= 1'b0;
    end
    else
    begin
      rq_q <= {rq_q[1:0], lt_q}; en_q <= {en_q[0], en}; os_q <= {os_q[0], osc_ok};
      chip_q <= chip_d; prot_q <= prot_d; nrw_q <= nrw_d; colc_q <= colc_d;
      colp_q <= colp_d; rd_q <= rd_d; cause_q <= cause_d; irq_q <= irq_d;
      wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d; txd_q <= txd_d;
      txa_q <= txa_d; rxa_q <= rxa_d; lvl_q <= lvl;
      nr_on_q <= nr_on_d; nr_left_q <= nr_left_d; nr_sub_q <= nr_sub_d;
      ck_q <= ck_d; div_q <= div_d; co_q <= co_d; se_q <= en_q[1];
    end
  end

  assign irq              = irq_q;
  assign tx_data          = txd_q;
  assign supply_osc_en    = se_q;
  assign reader_clock_out = co_q;

  a_tx_flag_start: assert property (@(posedge core_clk) disable iff (!rstn)
    ev.tx_start |=> cause_q[rirq_pkg::B_TX]) else $error("transmit start flag not latched");

  a_irq_after_end: assert property (@(posedge core_clk) disable iff (!rstn)
    (ev.tx_done || ev.rx_done) |=> irq_q) else $error("interrupt not raised at end of frame");

  a_rx_flag_start: assert property (@(posedge core_clk) disable iff (!rstn)
    ev.rx_start |=> cause_q[rirq_pkg::B_RX]) else $error("receive start flag not latched");

  a_crc_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cause_q[rirq_pkg::B_CRC]) |-> $past(ev.crc_err && !prot_q[rirq_pkg::B_CRC_OFF]))
    else $error("CRC cause set while disabled");

  a_col_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cause_q[rirq_pkg::B_COL]) |-> $past((ev.col_a && colc_q[0]) || (ev.col_v && colc_q[1])))
    else $error("collision cause set without enabled source");

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (!rstn)
    cnt_q <= rirq_pkg::FIFO_DEPTH) else $error("FIFO count above twelve");

  a_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (clr && !raise) |=> !irq_q ##0 (cause_q == $past(set_v))) else $error("cause read did not clear");

  a_fast_needs_osc: assert property (@(posedge core_clk) disable iff (!rstn)
    (ck_q == rirq_pkg::CK_FAST) && ($past(ck_q) != rirq_pkg::CK_FAST) |-> $past(os_q[1] && en_q[1]))
    else $error("fast clock selected before oscillator stable");

  a_level_fire: assert property (@(posedge core_clk) disable iff (!rstn)
    (lvl && !lvl_q) |=> cause_q[rirq_pkg::B_LVL] ##0 irq_q) else $error("FIFO level event lost");

endmodule

// ---- testbench/rirq_host.sv ----
module rirq_host (
  // Serial link towards the reader
  output logic       data_clk,
  output logic       ss_n,
  output logic       mosi,
  input  wire logic  miso,
  input  wire logic  miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Output enable as seen at the first sampling point of the latest frame.
  logic oe_seen;

  initial
  begin
    oe_seen  = 1'b0;
    data_clk = 1'b0;
    ss_n     = 1'b1;
    mosi     = 1'b0;
  end

  // The link clock stands still between frames, and every frame starts here.
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    int i;
    r = 8'h00;
    #3 ss_n = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      mosi = f[i];
      #6 data_clk = 1'b1;
      #6 if (i > 7) r = {r[6:0], miso};
      if (i == 15) oe_seen = miso_oe;
      data_clk = 1'b0;
    end
    // A released data line must not keep its last value.
    mosi = ~mosi;
    #3 ss_n = 1'b1;
    #120;
  endtask
endmodule

// ---- testbench/tb_rirq_core.sv ----
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_rirq_core;
  timeunit 1ns;
  timeprecision 100ps;

  logic               core_clk, rstn, data_clk, ss_n, mosi, miso, miso_oe;
  logic               rx_push, tx_pop, irq, en, osc_ok, supply_osc_en, reader_clock_out;
  rirq_pkg::rirq_ev_t ev;
  logic [7:0]         col_pos, rx_byte, tx_data, r;
  int                 bad_count, num_checks, n, i;

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  rirq_core u_rirq_core (.core_clk(core_clk), .rstn(rstn), .data_clk(data_clk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .ev(ev), .col_pos(col_pos), .rx_push(rx_push), .rx_byte(rx_byte),
    .tx_pop(tx_pop), .tx_data(tx_data), .irq(irq), .en(en), .osc_ok(osc_ok),
    .supply_osc_en(supply_osc_en), .reader_clock_out(reader_clock_out));
  rirq_host u_rirq_host (.data_clk(data_clk), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_rirq_host.xfer({1'b0, a, d}, x);
  endtask

  // The answer to a read arrives in the following frame.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] x;
    u_rirq_host.xfer({1'b1, a, 8'h00}, x);
    u_rirq_host.xfer({1'b1, rirq_pkg::A_CHIP, 8'h00}, d);
  endtask

  task automatic fire(input logic [8:0] e);
    @(posedge core_clk) ev <= rirq_pkg::rirq_ev_t'(e);
    @(posedge core_clk) ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge core_clk) rx_push <= 1'b1;
    rx_byte <= d;
    @(posedge core_clk) rx_push <= 1'b0;
  endtask

  task automatic half(output int c);
    int  k;
    logic v;
    v = reader_clock_out;
    for (k = 0; k < 2000 && reader_clock_out === v; k++) @(posedge core_clk);
    v = reader_clock_out;
    for (c = 0; c < 2000 && reader_clock_out === v; c++) @(posedge core_clk);
    if (c == 2000)
    begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic t_reset();
    rd(rirq_pkg::A_NRW, r);   `CHK("nrw", 8'h10, r)
    rd(rirq_pkg::A_COLC, r);  `CHK("colc", 8'h03, r)
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause", 8'h00, r)
    rd(7'h05, r);             `CHK("unmapped", 8'h00, r)
    wr(rirq_pkg::A_CHIP, 8'h21);
    wr(rirq_pkg::A_PROT, 8'h00);
    rd(rirq_pkg::A_CHIP, r);  `CHK("chip", 8'h21, r)
    `CHK("oe frame", 1'b1, u_rirq_host.oe_seen)
    `CHK("oe idle", 1'b0, miso_oe)
    $display("test reset done");
  endtask

  // Draining the FIFO during transmit below four bytes raises the level cause.
  task automatic t_txrx();
    for (i = 0; i < 5; i++) push(8'h11 + 8'(i));
    fire(9'h100);             `CHK("irq tx start", 1'b0, irq)
    @(posedge core_clk) tx_pop <= 1'b1;
    @(posedge core_clk) tx_pop <= 1'b0;
    @(posedge core_clk)       `CHK("tx data", 8'h11, tx_data)
    `CHK("irq 4 left", 1'b0, irq)
    fire(9'h000);
    @(posedge core_clk) tx_pop <= 1'b1;
    @(posedge core_clk) tx_pop <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK("irq 3 left", 1'b1, irq)
    fire(9'h080);
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause tx", 8'hA0, r)
    fire(9'h040);             `CHK("irq rx start", 1'b0, irq)
    fire(9'h020);             `CHK("irq rx done", 1'b1, irq)
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause rx", 8'h40, r)
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause clr", 8'h00, r)
    $display("test txrx done");
  endtask

  task automatic t_fifo();
    wr(rirq_pkg::A_FSTAT, 8'h00);
    fire(9'h040);
    for (i = 0; i < 13; i++) push(8'h30 + 8'(i));
    rd(rirq_pkg::A_FSTAT, r); `CHK("fifo count", 8'h0C, r)
    // The controller drains nine bytes on the level cause and then looks at the pin again.
    for (i = 0; i < 9; i++)
    begin
      rd(rirq_pkg::A_FIFO, r); `CHK("fifo data", 8'h30 + 8'(i), r)
    end
    `CHK("irq after drain", 1'b1, irq)
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause lvl", 8'h60, r)
    fire(9'h020);
    rd(rirq_pkg::A_IRQ, r);
    wr(rirq_pkg::A_FSTAT, 8'h00);
    wr(rirq_pkg::A_FIFO, 8'h5A);
    rd(rirq_pkg::A_FIFO, r);  `CHK("fifo link", 8'h5A, r)
    $display("test fifo done");
  endtask

  task automatic t_err();
    logic [7:0] exp_q [3] = '{8'h10, 8'h08, 8'h04};
    for (i = 0; i < 3; i++)
    begin
      fire(9'h010 >> i);      `CHK("irq err", 1'b1, irq)
      rd(rirq_pkg::A_IRQ, r); `CHK("cause err", exp_q[i], r)
    end
    wr(rirq_pkg::A_PROT, 8'h80);
    fire(9'h010);             `CHK("crc off", 1'b0, irq)
    wr(rirq_pkg::A_PROT, 8'h00);
    col_pos <= 8'h43;
    fire(9'h002);
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause col", 8'h02, r)
    rd(rirq_pkg::A_COLP, r);  `CHK("col pos", 8'h43, r)
    wr(rirq_pkg::A_COLC, 8'h01);
    fire(9'h001);             `CHK("col v off", 1'b0, irq)
    $display("test err done");
  endtask

  task automatic t_noresp();
    wr(rirq_pkg::A_NRW, 8'h01);
    fire(9'h080);
    repeat (300) @(posedge core_clk);
    rd(rirq_pkg::A_IRQ, r);   `CHK("cause nr", 8'h81, r)
    $display("test noresp done");
  endtask

  task automatic t_clk();
    half(n);                  `CHK("aux half", 1'b1, n >= 832 && n <= 835)
    @(posedge core_clk) en <= 1'b1;
    osc_ok <= 1'b1;
    repeat (5) @(posedge core_clk);
    `CHK("supply en", 1'b1, supply_osc_en)
    for (i = 0; i < 4; i++)
    begin
      half(n);
      if (n < 10) break;
    end
    half(n);                  `CHK("fast half", 4, n)
    $display("test clk done");
  endtask

  initial
  begin
    rstn = 1'b0;
    ev = '0;
    col_pos = 8'h00;
    rx_push = 1'b0;
    rx_byte = 8'h00;
    tx_pop = 1'b0;
    en = 1'b0;
    osc_ok = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_txrx();
    t_fifo();
    t_err();
    t_noresp();
    t_clk();
    give_verdict();
  end
endmodule
